// File: design/ops_strobe_slave.sv
// Device-side transaction framing, strobe and data path of the octal DDR slave
`timescale 1ns/10ps

module ops_strobe_slave
#(
  parameter int LAT_CLKS              = 4,
  parameter bit CENTERED_READ_STROBE  = 1'b1,
  parameter int BUF_W                 = 8,
  parameter int BUF_DEPTH             = 2
)
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Link pins
  input  wire logic             select_n,
  input  wire logic             bus_clock_true,
  input  wire logic             bus_clock_comp,
  input  wire logic             shifted_clock_true,
  input  wire logic             shifted_clock_comp,
  input  wire logic [7:0]       dq_in,
  output logic      [7:0]       dq_out,
  output logic                  dq_oe_n,
  input  wire logic             strobe_in,
  output logic                  strobe_out,
  output logic                  strobe_oe_n,
  // Configuration
  input  wire logic             clock_diff_mode,
  // Command and write data towards the core
  output logic [47:0]           cmd_word,
  output logic                  cmd_valid,
  output logic [7:0]            wr_data,
  output logic                  wr_mask,
  output logic                  wr_valid,
  // Read data from the core
  input  wire logic [BUF_W-1:0] rd_data,
  input  wire logic             rd_valid,
  output logic                  rd_ready
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int          LAT_EDGES = ops_pkg::LAT_MULT * ops_pkg::EDGES_PER_CK * LAT_CLKS;
  localparam logic [7:0]  LAT_LAST  = 8'(LAT_EDGES - 1);
  localparam logic [2:0]  CA_LAST   = 3'(ops_pkg::CA_BYTES - 1);
  localparam int          AW        = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int          CW        = $clog2(BUF_DEPTH + 1);
  localparam logic [CW-1:0] BUF_FULL = CW'(BUF_DEPTH);

  logic [ops_pkg::SYNC_W-1:0] pins_raw;
  logic [ops_pkg::SYNC_W-1:0] s1_q;
  logic [ops_pkg::SYNC_W-1:0] s2_q;
  logic [ops_pkg::SYNC_W-1:0] s3_q;
  logic [ops_pkg::SYNC_W-1:0] stable_q;

  assign pins_raw = {strobe_in, dq_in, shifted_clock_comp, shifted_clock_true,
                     bus_clock_comp, bus_clock_true, select_n};

  // A change counts only when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < ops_pkg::SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_q[gi]     <= ops_pkg::SYNC_RST[gi];
          s2_q[gi]     <= ops_pkg::SYNC_RST[gi];
          s3_q[gi]     <= ops_pkg::SYNC_RST[gi];
          stable_q[gi] <= ops_pkg::SYNC_RST[gi];
        end
        else
        begin
          s1_q[gi] <= pins_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            stable_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Clock edge and select event detection
  // ----------------------------------------------------------------
  logic       sel_prev_q;
  logic       bus_prev_q;
  logic       sh_prev_q;
  logic       bus_lvl;
  logic       sh_lvl;
  logic       bus_edge;
  logic       sh_edge;
  logic       sel_fall;
  logic       sel_rise;
  logic [7:0] pin_dq;
  logic       pin_stb;

  // Only edges are used, so a stopped bus clock simply pauses the sequence
  assign bus_lvl  = clock_diff_mode ? (stable_q[ops_pkg::SYN_BCT] & ~stable_q[ops_pkg::SYN_BCC])
                                    : stable_q[ops_pkg::SYN_BCT];
  assign sh_lvl   = clock_diff_mode ? (stable_q[ops_pkg::SYN_SCT] & ~stable_q[ops_pkg::SYN_SCC])
                                    : stable_q[ops_pkg::SYN_SCT];
  assign bus_edge = bus_lvl != bus_prev_q;
  assign sh_edge  = sh_lvl != sh_prev_q;
  assign sel_fall = sel_prev_q & ~stable_q[ops_pkg::SYN_SEL];
  assign sel_rise = ~sel_prev_q & stable_q[ops_pkg::SYN_SEL];
  assign pin_dq   = stable_q[ops_pkg::SYN_STB-1:ops_pkg::SYN_DQ];
  assign pin_stb  = stable_q[ops_pkg::SYN_STB];

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_prev_q <= 1'b1;
      bus_prev_q <= 1'b0;
      sh_prev_q  <= 1'b0;
    end
    else
    begin
      sel_prev_q <= stable_q[ops_pkg::SYN_SEL];
      bus_prev_q <= bus_lvl;
      sh_prev_q  <= sh_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Read data buffer
  // ----------------------------------------------------------------
  logic [BUF_W-1:0] buf_mem [BUF_DEPTH];
  logic [AW-1:0]    wptr_q;
  logic [AW-1:0]    rptr_q;
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    cnt_d;
  logic             push;
  logic             pop;
  logic             rd_q;
  ops_pkg::ops_state_t state_q;

  // Depth must be a power of two so the pointers wrap on their own
  assign push  = rd_valid & rd_ready;
  assign pop   = (state_q == ops_pkg::ST_DATA) & rd_q & bus_edge & (cnt_q != '0);
  assign cnt_d = cnt_q + CW'(push) - CW'(pop);

  always_ff @(posedge sys_clk)
  begin
    if (push)
      buf_mem[wptr_q] <= rd_data;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_q   <= '0;
      rptr_q   <= '0;
      cnt_q    <= '0;
      rd_ready <= 1'b0;
    end
    else
    begin
      wptr_q   <= wptr_q + AW'(push);
      rptr_q   <= rptr_q + AW'(pop);
      cnt_q    <= cnt_d;
      rd_ready <= cnt_d != BUF_FULL;
    end
  end

  // ----------------------------------------------------------------
  // Transaction sequencer
  // ----------------------------------------------------------------
  ops_pkg::ops_state_t state_d;
  logic [2:0]  ca_cnt_q;
  logic [7:0]  lat_cnt_q;
  logic [47:0] ca_next;
  logic        ca_done;
  logic        lat_done;
  logic        wr_beat;
  logic        stb_toggle;

  assign ca_next    = {cmd_word[39:0], pin_dq};
  assign ca_done    = (state_q == ops_pkg::ST_CA) & bus_edge & (ca_cnt_q == CA_LAST);
  assign lat_done   = (state_q == ops_pkg::ST_LAT) & bus_edge & (lat_cnt_q == LAT_LAST);
  assign wr_beat    = (state_q == ops_pkg::ST_DATA) & ~rd_q & bus_edge;
  // Writes never look at the shifted clock
  assign stb_toggle = (state_q == ops_pkg::ST_DATA) & rd_q &
                      (CENTERED_READ_STROBE ? sh_edge : bus_edge);

  always_comb
  begin
    state_d = state_q;
    if (sel_rise)
      state_d = ops_pkg::ST_IDLE;
    else if (sel_fall)
      state_d = ops_pkg::ST_CA;
    else if (ca_done)
      state_d = ops_pkg::ST_LAT;
    else if (lat_done)
      state_d = ops_pkg::ST_DATA;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q   <= ops_pkg::ST_IDLE;
      ca_cnt_q  <= '0;
      lat_cnt_q <= '0;
      rd_q      <= 1'b0;
      cmd_word  <= '0;
      cmd_valid <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      cmd_valid <= ca_done;
      if (sel_fall)
        ca_cnt_q <= '0;
      else if ((state_q == ops_pkg::ST_CA) & bus_edge)
        ca_cnt_q <= ca_cnt_q + 3'h1;
      if (state_q != ops_pkg::ST_LAT)
        lat_cnt_q <= '0;
      else if (bus_edge)
        lat_cnt_q <= lat_cnt_q + 8'h01;
      if ((state_q == ops_pkg::ST_CA) & bus_edge)
        cmd_word <= ca_next;
      if (ca_done)
        rd_q <= ca_next[ops_pkg::CA_DIR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers and write capture
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_out      <= ops_pkg::DQ_RST;
      dq_oe_n     <= ops_pkg::OE_N_RST;
      strobe_out  <= ops_pkg::STB_RST;
      strobe_oe_n <= ops_pkg::OE_N_RST;
      wr_data     <= '0;
      wr_mask     <= 1'b0;
      wr_valid    <= 1'b0;
    end
    else
    begin
      wr_valid <= wr_beat;
      if (wr_beat)
      begin
        wr_data <= pin_dq;
        wr_mask <= pin_stb;
      end
      if (sel_rise)
      begin
        dq_oe_n     <= 1'b1;
        strobe_oe_n <= 1'b1;
      end
      else if (sel_fall)
      begin
        // Strobe high means extra latency, and it always applies here
        strobe_out  <= 1'b1;
        strobe_oe_n <= 1'b0;
      end
      else if (ca_done)
      begin
        // Reads hold the strobe low through latency; writes hand it to the host
        strobe_out  <= 1'b0;
        strobe_oe_n <= ~ca_next[ops_pkg::CA_DIR_BIT];
      end
      else
      begin
        if (pop)
        begin
          dq_out  <= 8'(buf_mem[rptr_q]);
          dq_oe_n <= 1'b0;
        end
        if (stb_toggle)
          strobe_out <= ~strobe_out;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_select_start;
    sel_fall && !sel_rise;
  endsequence

  sequence s_deselect;
    sel_rise;
  endsequence

  sequence s_latency_exit;
    (state_q == ops_pkg::ST_LAT) ##1 (state_q == ops_pkg::ST_DATA);
  endsequence

  a_release_on_deselect: assert property (s_deselect |=> dq_oe_n && strobe_oe_n && state_q == ops_pkg::ST_IDLE)
    else $error("lines not released after deselect");

  a_idle_lines_float: assert property (state_q == ops_pkg::ST_IDLE |-> dq_oe_n && strobe_oe_n)
    else $error("lines driven while idle");

  a_latency_flag_high: assert property (s_select_start |=> !strobe_oe_n && strobe_out)
    else $error("strobe not flagging extra latency at start");

  a_doubled_latency: assert property (s_latency_exit |-> $past(lat_cnt_q) == LAT_LAST && $past(bus_edge))
    else $error("latency phase length wrong");

  a_write_mask_input: assert property ((state_q inside {ops_pkg::ST_LAT, ops_pkg::ST_DATA}) && !rd_q |-> strobe_oe_n)
    else $error("strobe driven during write");

  a_write_ignores_shift: assert property ((state_q == ops_pkg::ST_DATA) && !rd_q && !sel_rise |=> $stable(strobe_out))
    else $error("strobe moved during write");

  a_read_strobe_src: assert property ((state_q == ops_pkg::ST_DATA) && rd_q && !sel_rise &&
                                      (CENTERED_READ_STROBE ? sh_edge : bus_edge)
                                      |=> strobe_out != $past(strobe_out))
    else $error("read strobe missed its reference edge");

  a_ca_capture: assert property (cmd_valid |-> $past(state_q) == ops_pkg::ST_CA && $past(ca_cnt_q) == CA_LAST)
    else $error("command word completed early or late");

  a_write_byte: assert property (wr_beat |=> wr_valid && wr_data == $past(pin_dq) && wr_mask == $past(pin_stb))
    else $error("write byte not captured");

  // In single-ended mode a moving complement alone must never look like a bus clock edge
  a_single_ended: assert property (!clock_diff_mode && $stable(clock_diff_mode) &&
                                   $stable(stable_q[ops_pkg::SYN_BCT]) |-> !bus_edge)
    else $error("complement input moved the single-ended clock");

endmodule : ops_strobe_slave

// File: common/ops_pkg.sv
// Shared constants for the octal strobe interface slave
package ops_pkg;

  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  localparam int          CA_BYTES     = 6;
  localparam int          CA_BITS      = 48;
  localparam int          CA_DIR_BIT   = 47;
  localparam int          LAT_MULT     = 2;
  localparam int          EDGES_PER_CK = 2;

  // ----------------------------------------------------------------
  // Pin synchroniser layout and idle values
  // ----------------------------------------------------------------
  localparam int          SYNC_W       = 14;
  localparam int          SYN_SEL      = 0;
  localparam int          SYN_BCT      = 1;
  localparam int          SYN_BCC      = 2;
  localparam int          SYN_SCT      = 3;
  localparam int          SYN_SCC      = 4;
  localparam int          SYN_DQ       = 5;
  localparam int          SYN_STB      = 13;
  localparam logic [13:0] SYNC_RST     = 14'h0001;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic        OE_N_RST     = 1'b1;
  localparam logic [7:0]  DQ_RST       = 8'h00;
  localparam logic        STB_RST      = 1'b0;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_CA   = 2'b01,
    ST_LAT  = 2'b10,
    ST_DATA = 2'b11
  } ops_state_t;

endpackage : ops_pkg

// File: testbench/ops_host_model.sv
// Host-side model of the octal link: select, clocks, shared lines
`timescale 1ns/10ps

module ops_host_model
(
  // Pattern clock
  input  wire logic       sys_clk,
  // Host pins
  output logic            select_n,
  output logic            bus_clock_true,
  output logic            bus_clock_comp,
  output logic            shifted_clock_true,
  output logic            shifted_clock_comp,
  output logic      [7:0] dq_in,
  output logic            strobe_in,
  // Device drive
  input  wire logic [7:0] dq_out,
  input  wire logic       dq_oe_n,
  input  wire logic       strobe_out,
  input  wire logic       strobe_oe_n
);
  logic       diff;
  logic       dq_en;
  logic       stb_en;
  logic       data_ph;
  logic [7:0] dq_h;
  logic       stb_h;
  logic [7:0] rd_q[$];

  // Released lines show a moving pattern, never the last value
  assign dq_in     = !dq_oe_n ? dq_out : dq_en ? dq_h : {8{sys_clk}} ^ 8'h5A;
  assign strobe_in = !strobe_oe_n ? strobe_out : stb_en ? stb_h : ~sys_clk;

  initial
  begin
    diff = 1'b0;
    dq_en = 1'b0;
    stb_en = 1'b0;
    data_ph = 1'b0;
    dq_h = 8'h00;
    stb_h = 1'b0;
    select_n = 1'b1;
    bus_clock_true = 1'b0;
    bus_clock_comp = 1'b0;
    shifted_clock_true = 1'b0;
    shifted_clock_comp = 1'b0;
  end

  // Read bytes captured on both strobe edges
  always @(strobe_in)
    if (data_ph) rd_q.push_back(dq_in);

  // Pin changes land on falling edges, away from the slave's sampling edge
  task automatic mode(input logic d);
    @(negedge sys_clk);
    diff = d;
    bus_clock_comp = d & ~bus_clock_true;
    shifted_clock_comp = d & ~shifted_clock_true;
  endtask : mode

  // Frames start with the bus clock low and stay well under 4 us
  task automatic sel(input logic v);
    @(negedge sys_clk);
    #50 select_n = v;
    #250;
  endtask : sel

  // One bus edge; the clock stands still between calls
  task automatic step(input logic [7:0] d, input logic m, input logic sh);
    dq_h  = d;
    stb_h = m;
    #50 bus_clock_true = ~bus_clock_true;
    bus_clock_comp = diff & ~bus_clock_true;
    // Shifted copy 90 degrees late; held during writes and latency
    #50 if (sh)
    begin
      shifted_clock_true = ~shifted_clock_true;
      shifted_clock_comp = diff & ~shifted_clock_true;
    end
  endtask : step
endmodule : ops_host_model

// File: testbench/tb_top.sv
// Self-checking bench for the octal strobe slave
`timescale 1ns/10ps

module tb_top;
  logic        sys_clk, rst_n, select_n, bct, bcc, sct, scc;
  logic [7:0]  dq_in, dq_out, wr_data, rd_data;
  logic        dq_oe_n, strobe_in, strobe_out, strobe_oe_n, clock_diff_mode;
  logic [47:0] cmd_word, cmd_seen;
  logic        cmd_valid, wr_mask, wr_valid, rd_valid, rd_ready;
  logic [8:0]  wr_q[$];
  int          num_errors, compares;

  ops_strobe_slave ops_strobe_slave_inst
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .select_n(select_n),
    .bus_clock_true(bct), .bus_clock_comp(bcc), .shifted_clock_true(sct), .shifted_clock_comp(scc),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .strobe_in(strobe_in), .strobe_out(strobe_out), .strobe_oe_n(strobe_oe_n),
    .clock_diff_mode(clock_diff_mode), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
    .wr_data(wr_data), .wr_mask(wr_mask), .wr_valid(wr_valid),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready)
  );

  ops_host_model ops_host_model_inst
  (
    .sys_clk(sys_clk), .select_n(select_n),
    .bus_clock_true(bct), .bus_clock_comp(bcc), .shifted_clock_true(sct), .shifted_clock_comp(scc),
    .dq_in(dq_in), .strobe_in(strobe_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .strobe_out(strobe_out), .strobe_oe_n(strobe_oe_n)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (cmd_valid === 1'b1) cmd_seen <= cmd_word;
    if (wr_valid === 1'b1) wr_q.push_back({wr_mask, wr_data});
  end

  task automatic results;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // Holds valid up between pushes so back-to-back pushes never collide
  task automatic push(input logic [7:0] b);
    int n;
    rd_data  <= b;
    rd_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (rd_ready !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      num_errors++;
      results();
    end
  endtask : push

  // Six address bytes, then two latency steps before the strobe is judged
  task automatic send_ca(input logic [47:0] ca);
    for (int k = 0; k < 6; k++) ops_host_model_inst.step(ca[47-8*k -: 8], 1'b0, 1'b0);
    if (ca[47] === 1'b1) ops_host_model_inst.dq_en = 1'b0;
    repeat (2) ops_host_model_inst.step(8'hEE, 1'b0, 1'b0);
    chk("command word", ca, cmd_seen);
    chk("strobe after address", {~ca[47], 1'b0}, {strobe_oe_n, strobe_out});
    repeat (14) ops_host_model_inst.step(8'hEE, 1'b0, 1'b0);
  endtask : send_ca

  task automatic t_reset;
    cyc(5);
    chk("lines in reset", 3'b110, {dq_oe_n, strobe_oe_n, rd_ready});
    rst_n <= 1'b1;
    cyc(2);
    chk("ready after reset", 1'b1, rd_ready);
    cyc(5);
  endtask : t_reset

  task automatic t_write;
    wr_q.delete();
    ops_host_model_inst.dq_en = 1'b1;
    ops_host_model_inst.sel(1'b0);
    chk("start strobe", 2'b01, {strobe_oe_n, strobe_out});
    send_ca(48'h1234_5678_9ABC);
    ops_host_model_inst.stb_en = 1'b1;
    for (int i = 0; i < 4; i++) ops_host_model_inst.step(8'(8'hA0 + i), i[0], 1'b0);
    cyc(8);
    chk("write count", 4, wr_q.size());
    for (int i = 0; i < 4; i++) chk("write byte", {i[0], 8'(8'hA0 + i)}, wr_q[i]);
    ops_host_model_inst.stb_en = 1'b0;
    ops_host_model_inst.dq_en = 1'b0;
    ops_host_model_inst.sel(1'b1);
    chk("released after write", 2'b11, {dq_oe_n, strobe_oe_n});
  endtask : t_write

  // Reset mid-address must float the strobe and leave the slave idle
  task automatic t_abort;
    ops_host_model_inst.dq_en = 1'b1;
    ops_host_model_inst.sel(1'b0);
    repeat (3) ops_host_model_inst.step(8'h80, 1'b0, 1'b0);
    cyc(1);
    rst_n <= 1'b0;
    cyc(2);
    chk("reset mid frame", 3'b110, {dq_oe_n, strobe_oe_n, rd_ready});
    ops_host_model_inst.step(8'h80, 1'b0, 1'b0);
    ops_host_model_inst.dq_en = 1'b0;
    ops_host_model_inst.sel(1'b1);
    cyc(1);
    rst_n <= 1'b1;
    cyc(8);
  endtask : t_abort

  task automatic t_read(input logic d);
    cyc(1);
    clock_diff_mode <= d;
    ops_host_model_inst.mode(d);
    cyc(4);
    push(8'hC0);
    push(8'hC1);
    rd_valid <= 1'b0;
    cyc(2);
    chk("buffer full", 1'b0, rd_ready);
    fork
      begin
        push(8'hC2);
        push(8'hC3);
        rd_valid <= 1'b0;
      end
      begin
        ops_host_model_inst.dq_en = 1'b1;
        ops_host_model_inst.sel(1'b0);
        chk("start strobe", 2'b01, {strobe_oe_n, strobe_out});
        send_ca(48'hA011_2233_4455 ^ 48'(d));
        chk("latency strobe", 2'b00, {strobe_oe_n, strobe_out});
        ops_host_model_inst.rd_q.delete();
        ops_host_model_inst.data_ph = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
          ops_host_model_inst.step(8'h00, 1'b0, 1'b1);
          if (i == 1) #300;
        end
        #300 ops_host_model_inst.data_ph = 1'b0;
        chk("read strobe edges", 4, ops_host_model_inst.rd_q.size());
        for (int i = 0; i < 4; i++) chk("read byte", 8'hC0 + i, ops_host_model_inst.rd_q[i]);
        ops_host_model_inst.sel(1'b1);
        chk("released after read", 2'b11, {dq_oe_n, strobe_oe_n});
      end
    join
  endtask : t_read

  initial
  begin
    rst_n = 1'b0;
    clock_diff_mode = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
    cmd_seen = '0;
    num_errors = 0;
    compares = 0;
    t_reset();
    t_write();
    t_abort();
    t_read(1'b0);
    t_read(1'b1);
    results();
  end
endmodule : tb_top
